/* File: pkg/pmc_pkg.sv */
// shared constants, types and octet coding for the protection message codec
package pmc_pkg;

   // fixed octet values
   localparam logic [7:0] PMC_PD        = 8'h48;
   localparam logic [4:0] PMC_MT_HI     = 5'h03;
   localparam logic [7:0] PMC_IEI_SN    = 8'h50;
   localparam logic [7:0] PMC_IEI_PHY   = 8'h51;
   localparam logic [7:0] PMC_IEI_REJ   = 8'h52;
   localparam logic [7:0] PMC_IEI_PE    = 8'h53;
   localparam logic [7:0] PMC_LEN_SN    = 8'h01;
   localparam logic [7:0] PMC_LEN_PHY   = 8'h02;
   localparam logic [7:0] PMC_LEN_CS    = 8'h01;
   localparam logic [7:0] PMC_LEN_PEMAX = 8'h03;
   localparam logic [7:0] PMC_EXT       = 8'h80;

   // message type codes, low three bits
   localparam logic [2:0] PMC_T_SW_REQ  = 3'h0;
   localparam logic [2:0] PMC_T_SW_CMD  = 3'h1;
   localparam logic [2:0] PMC_T_OP_CMD  = 3'h2;
   localparam logic [2:0] PMC_T_SW_ACK  = 3'h3;
   localparam logic [2:0] PMC_T_SW_REJ  = 3'h4;
   localparam logic [2:0] PMC_T_PERR    = 3'h5;
   localparam logic [2:0] PMC_T_RST_CMD = 3'h6;
   localparam logic [2:0] PMC_T_RST_ACK = 3'h7;

   // message lengths in octets and octet index limit
   localparam logic [3:0] PMC_N_RST     = 4'h4;
   localparam logic [3:0] PMC_N_SW      = 4'hB;
   localparam logic [3:0] PMC_N_REJ     = 4'hE;
   localparam logic [3:0] PMC_N_PE      = 4'hA;
   localparam logic [3:0] PMC_IDX_SAT   = 4'hF;

   // type masks, bit n stands for type code n
   localparam logic [7:0] PMC_LE_TX     = 8'hD6;
   localparam logic [7:0] PMC_AN_TX     = 8'hF9;
   localparam logic [7:0] PMC_SEQ       = 8'h3F;

   typedef struct packed {
      logic [2:0]  mtype;
      logic [15:0] lcid;
      logic [6:0]  sn;
      logic [7:0]  link;
      logic [4:0]  slot;
      logic [6:0]  cause;
      logic [1:0]  ndiag;
      logic [15:0] diag;
   } pmc_msg_s;

   typedef enum logic {
      PMC_IDLE = 1'b0,
      PMC_SEND = 1'b1
   } pmc_tx_e;

   typedef struct packed {
      pmc_tx_e     st;
      logic [3:0]  tidx;
      logic [3:0]  tlen;
      pmc_msg_s    tmsg;
      logic        tvld;
      logic [7:0]  tdata;
      logic        tlast;
      logic [6:0]  tsn;
      logic        ack_pend;
      logic [3:0]  ridx;
      pmc_msg_s    rmsg;
      logic        rbad;
      logic        rsn_vld;
      logic [6:0]  rsn;
      logic        rx_vld;
      pmc_msg_s    rx_msg;
      logic        rx_err;
      logic        rx_dup;
      logic        tx_ref;
      logic        sn_clr;
   } pmc_end_s;

   localparam pmc_end_s PMC_END_RST = '0;

   // true for the two sequence-number reset messages
   function automatic logic pmc_is_rst(input pmc_msg_s m);
      return m.mtype == PMC_T_RST_CMD || m.mtype == PMC_T_RST_ACK;
   endfunction

   // total message length in octets
   function automatic logic [3:0] pmc_len(input pmc_msg_s m);
      logic [3:0] n;
      n = PMC_N_SW;
      case (m.mtype)
         PMC_T_RST_CMD, PMC_T_RST_ACK: n = PMC_N_RST;
         PMC_T_SW_REJ:                 n = PMC_N_REJ;
         PMC_T_PERR:                   n = PMC_N_PE + {2'b00, m.ndiag};
         default:                      n = PMC_N_SW;
      endcase
      return n;
   endfunction

   // octet i of the message, in element order
   function automatic logic [7:0] pmc_octet(input pmc_msg_s m,
                                            input logic [3:0] i);
      logic       pe;
      logic [7:0] o;
      pe = m.mtype == PMC_T_PERR;
      case (i)
         4'h0: o = PMC_PD;
         4'h1: o = pmc_is_rst(m) ? 8'h00 : m.lcid[15:8];
         4'h2: o = pmc_is_rst(m) ? 8'h00 : m.lcid[7:0];
         4'h3: o = {PMC_MT_HI, m.mtype};
         4'h4: o = PMC_IEI_SN;
         4'h5: o = PMC_LEN_SN;
         4'h6: o = PMC_EXT | {1'b0, m.sn};
         4'h7: o = pe ? PMC_IEI_PE : PMC_IEI_PHY;
         4'h8: o = pe ? {6'h00, m.ndiag} + PMC_LEN_CS : PMC_LEN_PHY;
         4'h9: o = pe ? PMC_EXT | {1'b0, m.cause} : m.link;
         4'hA: o = pe ? m.diag[15:8] : {3'h0, m.slot};
         4'hB: o = pe ? m.diag[7:0] : PMC_IEI_REJ;
         4'hC: o = PMC_LEN_CS;
         4'hD: o = PMC_EXT | {1'b0, m.cause};
         default: o = 8'h00;
      endcase
      return o;
   endfunction

   // octet d at index i does not fit message m
   function automatic logic pmc_bad(input pmc_msg_s m, input logic [3:0] i,
                                    input logic [7:0] d);
      logic pe;
      logic b;
      pe = m.mtype == PMC_T_PERR;
      case (i)
         4'h0: b = d != PMC_PD;
         4'h3: b = d[7:3] != PMC_MT_HI;
         4'h4: b = d != PMC_IEI_SN;
         4'h5: b = d != PMC_LEN_SN;
         4'h6: b = !d[7];
         4'h7: b = d != (pe ? PMC_IEI_PE : PMC_IEI_PHY);
         4'h8: b = pe ? (d == 8'h00 || d > PMC_LEN_PEMAX) : d != PMC_LEN_PHY;
         4'h9: b = pe && !d[7];
         4'hA: b = !pe && d[7:5] != 3'h0;
         4'hB: b = !pe && d != PMC_IEI_REJ;
         4'hC: b = d != PMC_LEN_CS;
         4'hD: b = !d[7];
         4'hE, 4'hF: b = 1'b1;
         default: b = 1'b0;
      endcase
      return b;
   endfunction

   // store octet d at index i into the fields of m
   function automatic pmc_msg_s pmc_absorb(input pmc_msg_s m,
                                           input logic [3:0] i,
                                           input logic [7:0] d);
      pmc_msg_s r;
      logic     pe;
      r  = m;
      pe = m.mtype == PMC_T_PERR;
      case (i)
         4'h0: r = '0;
         4'h1: r.lcid[15:8] = d;
         4'h2: r.lcid[7:0] = d;
         4'h3: r.mtype = d[2:0];
         4'h6: r.sn = d[6:0];
         4'h8: r.ndiag = pe ? d[1:0] - PMC_LEN_CS[1:0] : 2'b00;
         4'h9: begin
            if (pe) r.cause = d[6:0];
            else r.link = d;
         end
         4'hA: begin
            if (pe) r.diag[15:8] = d;
            else r.slot = d[4:0];
         end
         4'hB: begin
            if (pe) r.diag[7:0] = d;
         end
         4'hD: r.cause = d[6:0];
         default: r = m;
      endcase
      return r;
   endfunction

endpackage

/* File: pkg/pmc_link_if.sv */
// octet link between the exchange end and the access network end
`timescale 1ns/1ps
interface pmc_link_if;
   logic       le2an_vld;
   logic [7:0] le2an_data;
   logic       le2an_last;
   logic       an2le_vld;
   logic [7:0] an2le_data;
   logic       an2le_last;

   modport le (output le2an_vld, le2an_data, le2an_last,
               input  an2le_vld, an2le_data, an2le_last);
   modport an (input  le2an_vld, le2an_data, le2an_last,
               output an2le_vld, an2le_data, an2le_last);
endinterface

/* File: src/pmc_an_end.sv */
// access network end: framer and parser of protection messages
`timescale 1ns/1ps
module pmc_an_end (
   input  wire logic              I_CORE_CLK, // system clock
   input  wire logic              I_RESET_N,  // async reset, low
   pmc_link_if.an                 LINK,       // octet link to exchange
   input  wire logic              I_TX_REQ,   // send I_TX_MSG
   input  wire pmc_pkg::pmc_msg_s I_TX_MSG,   // fields to send
   output logic                   O_TX_BUSY,  // request not taken now
   output logic                   O_TX_REF,   // request refused pulse
   output logic                   O_RX_VLD,   // message received pulse
   output pmc_pkg::pmc_msg_s      O_RX_MSG,   // received fields
   output logic                   O_RX_ERR,   // bad message dropped
   output logic                   O_RX_DUP,   // duplicate dropped
   output logic                   O_SN_CLR    // sequence state zeroed
);

   pmc_pkg::pmc_end_s s;
   pmc_pkg::pmc_end_s n;
   pmc_pkg::pmc_msg_s m;
   pmc_pkg::pmc_msg_s rm;
   logic              tx_take;
   logic              bad;

   // next state of framer and parser
   always_comb begin
      n        = s;
      m        = I_TX_MSG;
      rm       = s.rmsg;
      bad      = s.rbad;
      tx_take  = 1'b0;
      n.rx_vld = 1'b0;
      n.rx_err = 1'b0;
      n.rx_dup = 1'b0;
      n.sn_clr = 1'b0;
      unique case (s.st)
         pmc_pkg::PMC_SEND: begin
            if (s.tlast) begin
               n.st    = pmc_pkg::PMC_IDLE;
               n.tvld  = 1'b0;
               n.tlast = 1'b0;
            end else begin
               n.tidx  = s.tidx + 4'h1;
               n.tdata = pmc_pkg::pmc_octet(s.tmsg, n.tidx);
               n.tlast = (s.tidx + 4'h2) == s.tlen;
            end
         end
         pmc_pkg::PMC_IDLE: begin
            if (s.ack_pend) begin
               m.mtype    = pmc_pkg::PMC_T_RST_ACK;
               n.ack_pend = 1'b0;
            end else if (I_TX_REQ &&
                         pmc_pkg::PMC_AN_TX[I_TX_MSG.mtype]) begin
               tx_take = 1'b1;
            end
            if (s.ack_pend || tx_take) begin
               m.sn = s.tsn;
               if (pmc_pkg::pmc_is_rst(m)) m.lcid = 16'h0000;
               if (pmc_pkg::PMC_SEQ[m.mtype])
                  n.tsn = s.tsn + 7'h01;
               n.tmsg  = m;
               n.tlen  = pmc_pkg::pmc_len(m);
               n.tidx  = 4'h0;
               n.tdata = pmc_pkg::pmc_octet(m, 4'h0);
               n.tvld  = 1'b1;
               n.tlast = 1'b0;
               n.st    = pmc_pkg::PMC_SEND;
            end
         end
      endcase
      n.tx_ref = I_TX_REQ && !tx_take;
      // parser: gather, check and act on whole messages
      if (LINK.le2an_vld) begin
         rm  = pmc_pkg::pmc_absorb(s.rmsg, s.ridx, LINK.le2an_data);
         bad = s.rbad | pmc_pkg::pmc_bad(rm, s.ridx, LINK.le2an_data);
         if (s.ridx == 4'h3 && !pmc_pkg::PMC_LE_TX[rm.mtype])
            bad = 1'b1;
         n.rmsg = rm;
         n.rbad = bad;
         if (s.ridx != pmc_pkg::PMC_IDX_SAT) n.ridx = s.ridx + 4'h1;
         if (LINK.le2an_last) begin
            n.ridx = 4'h0;
            n.rbad = 1'b0;
            if (bad || pmc_pkg::pmc_len(rm) != s.ridx + 4'h1) begin
               n.rx_err = 1'b1;
            end else if (pmc_pkg::pmc_is_rst(rm)) begin
               n.tsn     = 7'h00;
               n.rsn_vld = 1'b0;
               n.sn_clr  = 1'b1;
               n.rx_vld  = 1'b1;
               n.rx_msg  = rm;
               if (rm.mtype == pmc_pkg::PMC_T_RST_CMD)
                  n.ack_pend = 1'b1;
            end else if (s.rsn_vld && s.rsn == rm.sn) begin
               n.rx_dup = 1'b1;
            end else begin
               n.rx_vld  = 1'b1;
               n.rx_msg  = rm;
               n.rsn     = rm.sn;
               n.rsn_vld = 1'b1;
            end
         end
      end
   end

   // state register
   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) s <= pmc_pkg::PMC_END_RST;
      else s <= n;
   end

   // outputs
   assign LINK.an2le_vld  = s.tvld;
   assign LINK.an2le_data = s.tdata;
   assign LINK.an2le_last = s.tlast;
   assign O_TX_BUSY       = (s.st == pmc_pkg::PMC_SEND) || s.ack_pend;
   assign O_TX_REF        = s.tx_ref;
   assign O_RX_VLD        = s.rx_vld;
   assign O_RX_MSG        = s.rx_msg;
   assign O_RX_ERR        = s.rx_err;
   assign O_RX_DUP        = s.rx_dup;
   assign O_SN_CLR        = s.sn_clr;

endmodule

/* File: src/pmc_le_end.sv */
// exchange end: framer and parser of protection messages
`timescale 1ns/1ps

// Operation
// - type octet is 00011 plus three-bit code
// - access network asks switch-over by request
// - request: discriminator, channel, type, number, physical
// - exchange starts switch-over with command
// - command has same five elements, same lengths
// - operator command sent on operator request
// - operator command has the five elements
// - access network acknowledges with five elements
// - reject adds three-octet cause after five elements
// - protocol error: four elements, cause three-five
// - reset command: discriminator, channel, type only
// - reset command receiver zeroes sequence state
// - reset acknowledge follows, three elements only
// - logical channel is any 16-bit value
// - reset messages carry zero logical channel
// - 7-bit sequence number drops duplicate copies
// - physical channel: 8-bit link, 5-bit slot
module pmc_le_end (
   input  wire logic              I_CORE_CLK, // system clock
   input  wire logic              I_RESET_N,  // async reset, low
   pmc_link_if.le                 LINK,       // octet link to AN
   input  wire logic              I_TX_REQ,   // send I_TX_MSG
   input  wire logic              I_OS_REQ,   // operator switch-over
   input  wire pmc_pkg::pmc_msg_s I_TX_MSG,   // fields to send
   output logic                   O_TX_BUSY,  // request not taken now
   output logic                   O_TX_REF,   // request refused pulse
   output logic                   O_RX_VLD,   // message received pulse
   output pmc_pkg::pmc_msg_s      O_RX_MSG,   // received fields
   output logic                   O_RX_ERR,   // bad message dropped
   output logic                   O_RX_DUP,   // duplicate dropped
   output logic                   O_SN_CLR    // sequence state zeroed
);

   pmc_pkg::pmc_end_s s;
   pmc_pkg::pmc_end_s n;
   pmc_pkg::pmc_msg_s m;
   pmc_pkg::pmc_msg_s rm;
   logic              tx_take;
   logic              os_take;
   logic              bad;
   logic              short_msg;

   // next state of framer and parser
   always_comb begin
      n         = s;
      m         = I_TX_MSG;
      rm        = s.rmsg;
      bad       = s.rbad;
      short_msg = 1'b0;
      tx_take   = 1'b0;
      os_take   = 1'b0;
      n.rx_vld  = 1'b0;
      n.rx_err  = 1'b0;
      n.rx_dup  = 1'b0;
      n.sn_clr  = 1'b0;

      // framer: one octet per cycle, a gap cycle between messages
      unique case (s.st)
         pmc_pkg::PMC_SEND: begin
            if (s.tlast) begin
               n.st    = pmc_pkg::PMC_IDLE;
               n.tvld  = 1'b0;
               n.tlast = 1'b0;
            end else begin
               n.tidx  = s.tidx + 4'h1;
               n.tdata = pmc_pkg::pmc_octet(s.tmsg, n.tidx);
               n.tlast = (s.tidx + 4'h2) == s.tlen;
            end
         end
         pmc_pkg::PMC_IDLE: begin
            // pending acknowledge first, then operator, then user
            if (s.ack_pend) begin
               m.mtype    = pmc_pkg::PMC_T_RST_ACK;
               n.ack_pend = 1'b0;
            end else if (I_OS_REQ) begin
               m.mtype = pmc_pkg::PMC_T_OP_CMD;
               os_take = 1'b1;
            end else if (I_TX_REQ &&
                         pmc_pkg::PMC_LE_TX[I_TX_MSG.mtype]) begin
               tx_take = 1'b1;
            end
            // load the message and its first octet
            if (s.ack_pend || os_take || tx_take) begin
               m.sn = s.tsn;
               if (pmc_pkg::pmc_is_rst(m)) begin
                  m.lcid = 16'h0000;
               end
               if (pmc_pkg::PMC_SEQ[m.mtype]) begin
                  n.tsn = s.tsn + 7'h01;
               end
               n.tmsg  = m;
               n.tlen  = pmc_pkg::pmc_len(m);
               n.tidx  = 4'h0;
               n.tdata = pmc_pkg::pmc_octet(m, 4'h0);
               n.tvld  = 1'b1;
               n.tlast = 1'b0;
               n.st    = pmc_pkg::PMC_SEND;
            end
         end
      endcase

      // a request that was not taken this cycle is refused
      n.tx_ref = (I_TX_REQ && !tx_take) || (I_OS_REQ && !os_take);

      // parser: gather octets and check each against its place
      if (LINK.an2le_vld) begin
         rm  = pmc_pkg::pmc_absorb(s.rmsg, s.ridx, LINK.an2le_data);
         bad = s.rbad | pmc_pkg::pmc_bad(rm, s.ridx, LINK.an2le_data);
         // only types the access network may send are accepted
         if (s.ridx == 4'h3 && !pmc_pkg::PMC_AN_TX[rm.mtype]) begin
            bad = 1'b1;
         end
         n.rmsg = rm;
         n.rbad = bad;
         if (s.ridx != pmc_pkg::PMC_IDX_SAT) begin
            n.ridx = s.ridx + 4'h1;
         end
         // act on the whole message at its last octet
         if (LINK.an2le_last) begin
            n.ridx    = 4'h0;
            n.rbad    = 1'b0;
            short_msg = pmc_pkg::pmc_len(rm) != s.ridx + 4'h1;
            if (bad || short_msg) begin
               n.rx_err = 1'b1;
            end else if (pmc_pkg::pmc_is_rst(rm)) begin
               n.tsn     = 7'h00;
               n.rsn_vld = 1'b0;
               n.sn_clr  = 1'b1;
               n.rx_vld  = 1'b1;
               n.rx_msg  = rm;
               if (rm.mtype == pmc_pkg::PMC_T_RST_CMD) begin
                  n.ack_pend = 1'b1;
               end
            end else if (s.rsn_vld && s.rsn == rm.sn) begin
               n.rx_dup = 1'b1;
            end else begin
               n.rx_vld  = 1'b1;
               n.rx_msg  = rm;
               n.rsn     = rm.sn;
               n.rsn_vld = 1'b1;
            end
         end
      end
   end

   // state register
   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         s <= pmc_pkg::PMC_END_RST;
      end else begin
         s <= n;
      end
   end

   // link side outputs
   assign LINK.le2an_vld  = s.tvld;
   assign LINK.le2an_data = s.tdata;
   assign LINK.le2an_last = s.tlast;

   // user side outputs
   assign O_TX_BUSY = (s.st == pmc_pkg::PMC_SEND) || s.ack_pend;
   assign O_TX_REF  = s.tx_ref;
   assign O_RX_VLD  = s.rx_vld;
   assign O_RX_MSG  = s.rx_msg;
   assign O_RX_ERR  = s.rx_err;
   assign O_RX_DUP  = s.rx_dup;
   assign O_SN_CLR  = s.sn_clr;

endmodule

/* File: testbench/pmc_monitor.sv */
// link-level checks between the exchange and access network ends
`timescale 1ns/1ps
module pmc_monitor (
   input  wire logic       I_CORE_CLK, // system clock
   input  wire logic       I_RESET_N,  // async reset, low
   input  wire logic       le2an_vld,  // exchange octet valid
   input  wire logic [7:0] le2an_data, // exchange octet
   input  wire logic       le2an_last, // exchange final octet
   input  wire logic       an2le_vld,  // access octet valid
   input  wire logic [7:0] an2le_data, // access octet
   input  wire logic       an2le_last  // access final octet
);
   logic [3:0] le_idx; // octet position, each direction
   logic [3:0] an_idx;
   logic       le_t3;  // type octet on the link now
   logic       an_t3;

   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RESET_N);

   // type octet strobes
   assign le_t3 = le2an_vld && le_idx == 4'h3;
   assign an_t3 = an2le_vld && an_idx == 4'h3;

   // octet position counters, back to zero after a final octet
   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         le_idx <= 4'h0;
         an_idx <= 4'h0;
      end else begin
         if (le2an_vld) le_idx <= le2an_last ? 4'h0 : le_idx + 4'h1;
         if (an2le_vld) an_idx <= an2le_last ? 4'h0 : an_idx + 4'h1;
      end
   end

   // seven more octets of a switch message, final one flagged
   sequence s_le_sw;
      ##1 (le2an_vld && !le2an_last) [*6] ##1 (le2an_vld && le2an_last);
   endsequence
   sequence s_an_sw;
      ##1 (an2le_vld && !an2le_last) [*6] ##1 (an2le_vld && an2le_last);
   endsequence
   // sequence number element: identifier, length, flagged number
   sequence s_sn_ie;
      le2an_data == 8'h50 ##1 le2an_data == 8'h01 ##1 le2an_data[7];
   endsequence

   // framing and element order
   a_pd_first: assert property (le2an_vld && le_idx == 4'h0
      |-> le2an_data == 8'h48) else $error("discriminator octet wrong");
   a_type_hi: assert property (le_t3 |-> le2an_data[7:3] == 5'h03)
      else $error("exchange type octet high bits wrong");
   a_type_hi_an: assert property (an_t3
      |-> an2le_data[7:3] == 5'h03) else $error("access type octet wrong");
   a_le_types: assert property (le_t3
      |-> le2an_data[2:0] inside {3'h1, 3'h2, 3'h4, 3'h6, 3'h7})
      else $error("exchange sent a type of the other side");
   a_sw_len: assert property (le_t3 && !le2an_data[2] |-> s_le_sw)
      else $error("exchange switch message length wrong");
   a_an_sw_len: assert property (an_t3 && !an2le_data[2]
      |-> s_an_sw) else $error("access switch message length wrong");
   a_rej_len: assert property (le_t3 && le2an_data[2:0] == 3'h4
      |-> ##1 (le2an_vld && !le2an_last) [*8] ##1 (le2an_vld && !le2an_last)
      ##1 (le2an_vld && le2an_last)) else $error("reject length wrong");
   a_sn_elem: assert property (le2an_vld && le_idx == 4'h4
      |-> s_sn_ie) else $error("sequence number element wrong");
   a_rst_zero: assert property (le_t3 && le2an_data[2:1] == 2'b11
      |-> le2an_last && $past(le2an_data, 1) == 8'h00
      && $past(le2an_data, 2) == 8'h00) else $error("exchange reset msg");
   a_rst_an: assert property (an_t3 && an2le_data[2:1] == 2'b11
      |-> an2le_last && $past(an2le_data, 1) == 8'h00
      && $past(an2le_data, 2) == 8'h00) else $error("access reset msg");
   a_slot_bits: assert property (le2an_vld && le_idx == 4'hA
      |-> le2an_data[7:5] == 3'h0) else $error("slot octet too wide");
   a_perr_ie: assert property (an_t3 && an2le_data[2:0] == 3'h5
      |-> ##4 an2le_data == 8'h53 ##1 an2le_data inside {[8'h01:8'h03]})
      else $error("protocol error cause element wrong");
endmodule

/* File: testbench/protection_msg_codec_test.sv */
// bench joining both codec ends, plus a lone exchange end fed by hand
`timescale 1ns/1ps
module protection_msg_codec_test;
   logic              I_CORE_CLK;
   logic              I_RESET_N;
   logic [1:0]        tx_req;      // index 0 exchange, 1 access
   logic              os_req;      // operator request
   pmc_pkg::pmc_msg_s tx_msg [2];
   pmc_pkg::pmc_msg_s rx_msg [2];
   logic [1:0]        busy, refp, rxv, rxe, rxd, clr;
   logic [2:0]        b_rx;        // lone end: valid, error, duplicate
   logic [6:0]        sn [2];      // next number each end sends
   logic [63:0]       q [2][$];    // notes per receiving end
   logic [63:0]       note;
   logic [2:0]        an_t [6] = '{3'h0, 3'h3, 3'h4, 3'h5, 3'h5, 3'h5};
   logic [7:0]        fr [11] = '{8'h48, 8'h12, 8'h34, 8'h18, 8'h50,
                       8'h01, 8'h85, 8'h51, 8'h02, 8'h07, 8'h03};
   int                fails = 0;
   int                n_compared = 0;

   pmc_link_if link_if ();
   pmc_link_if link_b_if ();

   // design ends
   pmc_le_end pmc_le_end_inst (.I_CORE_CLK(I_CORE_CLK),
      .I_RESET_N(I_RESET_N), .LINK(link_if), .I_TX_REQ(tx_req[0]),
      .I_OS_REQ(os_req), .I_TX_MSG(tx_msg[0]), .O_TX_BUSY(busy[0]),
      .O_TX_REF(refp[0]), .O_RX_VLD(rxv[0]), .O_RX_MSG(rx_msg[0]),
      .O_RX_ERR(rxe[0]), .O_RX_DUP(rxd[0]), .O_SN_CLR(clr[0]));
   pmc_an_end pmc_an_end_inst (.I_CORE_CLK(I_CORE_CLK),
      .I_RESET_N(I_RESET_N), .LINK(link_if), .I_TX_REQ(tx_req[1]),
      .I_TX_MSG(tx_msg[1]), .O_TX_BUSY(busy[1]),
      .O_TX_REF(refp[1]), .O_RX_VLD(rxv[1]), .O_RX_MSG(rx_msg[1]),
      .O_RX_ERR(rxe[1]), .O_RX_DUP(rxd[1]), .O_SN_CLR(clr[1]));
   pmc_le_end pmc_le_end_inst_b (.I_CORE_CLK(I_CORE_CLK),
      .I_RESET_N(I_RESET_N), .LINK(link_b_if), .I_TX_REQ(1'b0),
      .I_OS_REQ(1'b0), .I_TX_MSG('0), .O_TX_BUSY(), .O_TX_REF(),
      .O_RX_VLD(b_rx[2]), .O_RX_MSG(), .O_RX_ERR(b_rx[1]),
      .O_RX_DUP(b_rx[0]), .O_SN_CLR());
   pmc_monitor pmc_monitor_inst (.I_CORE_CLK(I_CORE_CLK),
      .I_RESET_N(I_RESET_N), .le2an_vld(link_if.le2an_vld),
      .le2an_data(link_if.le2an_data), .le2an_last(link_if.le2an_last),
      .an2le_vld(link_if.an2le_vld), .an2le_data(link_if.an2le_data),
      .an2le_last(link_if.an2le_last));

   // clock
   initial begin
      I_CORE_CLK = 1'b0;
      forever #5 I_CORE_CLK = ~I_CORE_CLK;
   end

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // fields the receiver should report for a sent message
   function automatic logic [63:0] exp_of(input pmc_pkg::pmc_msg_s m,
                                          input logic [6:0] s);
      pmc_pkg::pmc_msg_s e;
      e = '0;
      e.mtype = m.mtype;
      if (m.mtype[2:1] == 2'b11) return e;
      e.lcid = m.lcid;
      e.sn = s;
      if (m.mtype == 3'h5) begin
         e.cause = m.cause;
         e.ndiag = m.ndiag;
         e.diag[15:8] = m.ndiag != 2'h0 ? m.diag[15:8] : 8'h00;
         e.diag[7:0] = m.ndiag == 2'h2 ? m.diag[7:0] : 8'h00;
      end else begin
         e.link = m.link;
         e.slot = m.slot;
         if (m.mtype == 3'h4) e.cause = m.cause;
      end
      return e;
   endfunction

   function automatic pmc_pkg::pmc_msg_s rnd(input logic [2:0] t);
      pmc_pkg::pmc_msg_s m;
      m = {$urandom, $urandom};
      m.mtype = t;
      m.ndiag = 2'($urandom_range(2));
      return m;
   endfunction

   // one request on end a; go: expected to be sent; er: refusal pulse
   task automatic send(input int a, input pmc_pkg::pmc_msg_s m,
      input logic os, input logic tx, input logic go, input logic er);
      int k;
      k = 0;
      @(negedge I_CORE_CLK);
      while (go && busy[a] !== 1'b0 && k < 100) begin
         @(negedge I_CORE_CLK);
         k++;
      end
      tx_msg[a] = m;
      tx_req[a] = tx;
      os_req = os;
      @(negedge I_CORE_CLK);
      tx_req[a] = 1'b0;
      os_req = 1'b0;
      check(refp[a], er);
      if (go) check(busy[a], 1'b1);
      if (go) begin
         if (os) m.mtype = pmc_pkg::PMC_T_OP_CMD;
         q[1 - a].push_back(exp_of(m, sn[a]));
         if (m.mtype < 3'h6) sn[a]++;
      end
   endtask

   task automatic drain;
      int k;
      k = 0;
      while ((q[0].size() != 0 || q[1].size() != 0) && k < 400) begin
         @(negedge I_CORE_CLK);
         k++;
      end
      check(k < 400, 1'b1);
   endtask

   // lone end: n octets, octet p replaced by v, then flag check
   task automatic feed(input int n, input int p, input logic [7:0] v,
                       input logic [2:0] exp);
      for (int i = 0; i < n; i++) begin
         @(negedge I_CORE_CLK);
         link_b_if.an2le_vld = 1'b1;
         link_b_if.an2le_data = i == p ? v : fr[i];
         link_b_if.an2le_last = i == n - 1;
      end
      @(negedge I_CORE_CLK);
      link_b_if.an2le_vld = 1'b0;
      link_b_if.an2le_last = 1'b0;
      link_b_if.an2le_data = ~link_b_if.an2le_data; // released line
      check(b_rx, exp);
   endtask

   // each reported message against the oldest note of that end
   always @(negedge I_CORE_CLK) begin
      for (int r = 0; r < 2; r++) begin
         if (rxv[r] === 1'b1 && q[r].size() == 0) check(1'b1, 1'b0);
         else if (rxv[r] === 1'b1) begin
            note = q[r].pop_front();
            check(rx_msg[r], note);
            check(clr[r], note[63:62] == 2'b11);
            if (note[63:62] == 2'b11) sn[r] = 7'h00;
            if (note[63:61] == 3'h6) q[1 - r].push_back({3'h7, 61'h0});
         end
         check({rxe[r], rxd[r]}, 2'b00);
      end
   end

   // main sequence
   initial begin
      I_RESET_N = 1'b0;
      tx_req = 2'b00;
      os_req = 1'b0;
      tx_msg = '{default: '0};
      sn = '{default: '0};
      link_b_if.an2le_vld = 1'b0;
      link_b_if.an2le_data = 8'h00;
      link_b_if.an2le_last = 1'b0;
      void'($urandom(44));
      repeat (2) @(posedge I_CORE_CLK);
      @(negedge I_CORE_CLK);
      I_RESET_N = 1'b1;
      send(0, rnd(3'h1), 1'b0, 1'b1, 1'b1, 1'b0);
      send(0, rnd(3'h1), 1'b0, 1'b1, 1'b0, 1'b1);
      send(0, rnd(3'h4), 1'b1, 1'b1, 1'b1, 1'b1);
      send(0, rnd(3'h4), 1'b0, 1'b1, 1'b1, 1'b0);
      send(0, rnd(3'h0), 1'b0, 1'b1, 1'b0, 1'b1);
      send(1, rnd(3'h1), 1'b0, 1'b1, 1'b0, 1'b1);
      for (int i = 0; i < 6; i++)
         send(1, rnd(an_t[i]), 1'b0, 1'b1, 1'b1, 1'b0);
      send(0, rnd(3'h6), 1'b0, 1'b1, 1'b1, 1'b0);
      drain();
      send(0, rnd(3'h1), 1'b0, 1'b1, 1'b1, 1'b0);
      send(1, rnd(3'h6), 1'b0, 1'b1, 1'b1, 1'b0);
      drain();
      send(1, rnd(3'h0), 1'b0, 1'b1, 1'b1, 1'b0);
      send(0, rnd(3'h7), 1'b0, 1'b1, 1'b1, 1'b0);
      drain();
      feed(11, 15, 8'h00, 3'b100);
      feed(11, 15, 8'h00, 3'b001);
      feed(11, 3, 8'h38, 3'b010);
      feed(7, 15, 8'h00, 3'b010);
      feed(11, 3, 8'h19, 3'b010);
      feed(11, 10, 8'h23, 3'b010);
      end_sim();
   end

   // watchdog
   initial begin
      #100us;
      fails++;
      end_sim();
   end
endmodule
